/* logic/rcf_regs.svh */
`ifndef RCF_REGS_SVH
`define RCF_REGS_SVH
// register indices; byte address is four times the index
`define RCF_IDX_FLAGS 10'h08e
`define RCF_IDX_STATUS 10'h08f
`define RCF_IDX_MASK 10'h090
// flag field positions
`define RCF_BIT_BROWN 0
`define RCF_BIT_POR 1
`define RCF_BIT_PIN 2
`define RCF_BIT_DOG 3
// reset values
`define RCF_FLAGS_RST 2'h0
`define RCF_STATUS_RST 4'h0
`define RCF_MASK_RST 4'h0
// timing: clock rate and least qualified pin pulse
`define RCF_CLK_MHZ 40
`define RCF_FILT_NS 2000
`define RCF_FILT_CYC ((`RCF_FILT_NS * `RCF_CLK_MHZ + 999) / 1000)
`endif

/* logic/rcf_pkg.sv */
`default_nettype none
package rcf_pkg;
  typedef logic [7:0] rcf_byte_t;
  typedef logic [9:0] rcf_index_t;
  typedef logic [3:0] rcf_events_t;
  typedef logic [7:0] rcf_count_t;
  typedef enum logic [1:0] {
    RCF_FILT_IDLE,
    RCF_FILT_COUNT,
    RCF_FILT_HOLD
  } rcf_filt_state_t;
endpackage
`default_nettype wire

/* logic/rcf_pin_if.sv */
`timescale 1ns/1ps
`default_nettype none
// carries the synchronised pin level to the filter and its verdict back
interface rcf_pin_if;
  logic pin_low;
  logic req_level;
  logic req_pulse;
  modport src (output pin_low, input req_level, input req_pulse);
  modport filt (input pin_low, output req_level, output req_pulse);
endinterface
`default_nettype wire

/* logic/rcf_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rcf_sync #(
  parameter int W = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import rcf_pkg::*;
  logic [W-1:0] meta_q;
  // two flops per bit; meta_q feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (rst) begin
          meta_q[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule // rcf_sync
`default_nettype wire

/* logic/rcf_pin_filter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rcf_regs.svh"
module rcf_pin_filter (
  input wire logic clock,
  input wire logic rst,
  rcf_pin_if.filt pin
);
  import rcf_pkg::*;
  localparam rcf_count_t FILT_CYC = rcf_count_t'(`RCF_FILT_CYC);
  rcf_filt_state_t state_q;
  rcf_count_t cnt_q;
  // a low pulse counts only once it has lasted the whole filter time
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= RCF_FILT_IDLE;
      cnt_q <= 8'h00;
      pin.req_level <= 1'b0;
      pin.req_pulse <= 1'b0;
    end else begin
      pin.req_pulse <= 1'b0;
      case (state_q)
        RCF_FILT_IDLE: begin
          cnt_q <= 8'h00;
          if (pin.pin_low) begin
            state_q <= RCF_FILT_COUNT;
            cnt_q <= 8'h01;
          end
        end
        RCF_FILT_COUNT: begin
          if (!pin.pin_low) begin
            state_q <= RCF_FILT_IDLE; // short glitch dropped
            cnt_q <= 8'h00;
          end else if (cnt_q == FILT_CYC) begin
            state_q <= RCF_FILT_HOLD;
            pin.req_level <= 1'b1;
            pin.req_pulse <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        RCF_FILT_HOLD: begin
          if (!pin.pin_low) begin
            state_q <= RCF_FILT_IDLE;
            pin.req_level <= 1'b0;
          end
        end
        default: state_q <= RCF_FILT_IDLE;
      endcase
    end
  end
  a_filter_qualify: assert property (@(posedge clock) disable iff (rst)
    $rose(pin.req_level) |-> $past(cnt_q) == FILT_CYC && $past(pin.pin_low))
    else $error("pin request without a full-length low pulse");
  c_filter_glitch: cover property (@(posedge clock) disable iff (rst)
    state_q == RCF_FILT_COUNT ##1 state_q == RCF_FILT_IDLE);
endmodule // rcf_pin_filter
`default_nettype wire

/* logic/rcf_top.sv */
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "rcf_regs.svh"
module rcf_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_reset_pin_n,
  input wire logic brownout_event,
  input wire logic brownout_detect_enable,
  input wire logic watchdog_timer_reset,
  output logic external_reset_req,
  output logic power_on_flag,
  output logic brownout_flag,
  output logic irq
);
  import rcf_pkg::*;

  // index decode, used by read and write paths
  function automatic logic hit(input rcf_index_t idx, input rcf_index_t reg_idx);
    hit = (idx == reg_idx);
  endfunction

  rcf_pin_if pin_bus ();
  logic [2:0] async_in;
  logic [2:0] sync_q;
  logic pin_low_s;
  logic brown_level_s;
  logic bod_en_s;
  logic brown_level_q;
  logic boot_q;
  logic brown_evt;
  logic por_evt;
  logic ack_d;
  logic wr_now;
  logic rd_hit_flags;
  rcf_index_t idx;
  logic [1:0] flags_q;
  logic [1:0] flags_d;
  rcf_events_t status_q;
  rcf_events_t status_d;
  rcf_events_t mask_q;
  rcf_events_t events;
  rcf_byte_t rd_byte;

  // the reset pin, the brown-out input and the config strap cross two flops first; the watchdog input does not
  assign async_in = {brownout_detect_enable, brownout_event, ~external_reset_pin_n};
  rcf_sync #(.W(3)) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in(async_in),
    .sync_out(sync_q)
  );
  assign pin_low_s = sync_q[0];
  assign brown_level_s = sync_q[1];
  assign bod_en_s = sync_q[2];
  assign pin_bus.pin_low = pin_low_s;

  // pin qualification lives in its own module
  rcf_pin_filter u_filter (
    .clock(clock),
    .rst(rst),
    .pin(pin_bus.filt)
  );

  // rising edge of the synchronised brown-out level
  always_ff @(posedge clock) begin
    if (rst) begin
      brown_level_q <= 1'b0;
    end else begin
      brown_level_q <= brown_level_s;
    end
  end
  // a brown-out only counts while detection is on
  assign brown_evt = brown_level_s && !brown_level_q && bod_en_s;

  // rst is the power-on reset; boot_q marks the first cycle after it
  always_ff @(posedge clock) begin
    if (rst) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end
  assign por_evt = boot_q;

  // bus decode; write lands on the edge where the master sees ack
  assign idx = wb_adr_i[11:2];
  assign ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_now = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign rd_hit_flags = hit(idx, `RCF_IDX_FLAGS);

  // flag next value: software sets or clears, a brown-out clears
  always_comb begin
    flags_d = flags_q;
    if (wr_now && hit(idx, `RCF_IDX_FLAGS)) begin
      flags_d = wb_dat_i[1:0]; // upper bits dropped
    end
    // hardware clear wins over a write in the same cycle
    if (brown_evt) begin
      flags_d[`RCF_BIT_BROWN] = 1'b0;
    end
    // pin and watchdog events deliberately absent here
  end

  // reset value 0 marks the power-on; brown-out bit is don't-care then
  always_ff @(posedge clock) begin
    if (rst) begin
      flags_q <= `RCF_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // one sticky status bit per reset cause
  assign events = {watchdog_timer_reset, pin_bus.req_pulse, por_evt, brown_evt};
  always_comb begin
    status_d = status_q;
    if (wr_now && hit(idx, `RCF_IDX_STATUS)) begin
      status_d = status_q & ~wb_dat_i[3:0];
    end
    status_d = status_d | events; // set beats write-one-clear
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      status_q <= `RCF_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge clock) begin
    if (rst) begin
      mask_q <= `RCF_MASK_RST;
    end else if (wr_now && hit(idx, `RCF_IDX_MASK)) begin
      mask_q <= wb_dat_i[3:0];
    end
  end

  // read mux; unmapped indices answer zero rather than stalling the bus
  always_comb begin
    rd_byte = 8'h00;
    if (rd_hit_flags) begin
      rd_byte = {6'h00, flags_q};
    end else if (hit(idx, `RCF_IDX_STATUS)) begin
      rd_byte = {4'h0, status_q};
    end else if (hit(idx, `RCF_IDX_MASK)) begin
      rd_byte = {4'h0, mask_q};
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= ack_d;
      wb_dat_o <= ack_d ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // registered outputs; irq lags status by one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
      external_reset_req <= 1'b0;
      power_on_flag <= 1'b0;
      brownout_flag <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
      external_reset_req <= pin_bus.req_level;
      power_on_flag <= flags_q[`RCF_BIT_POR];
      brownout_flag <= flags_q[`RCF_BIT_BROWN];
    end
  end

  a_por_flag_low: assert property (@(posedge clock)
    $fell(rst) |-> flags_q[`RCF_BIT_POR] == 1'b0 && status_d[`RCF_BIT_POR])
    else $error("power-on flag not low after reset");

  a_brown_flag_clear: assert property (@(posedge clock) disable iff (rst)
    brown_evt |=> flags_q[`RCF_BIT_BROWN] == 1'b0 ##1 brownout_flag == 1'b0)
    else $error("brown-out did not clear its flag");

  a_flag_write_set: assert property (@(posedge clock) disable iff (rst)
    wr_now && hit(idx, `RCF_IDX_FLAGS) && wb_dat_i[1] && !brown_evt
    |=> flags_q == {1'b1, $past(wb_dat_i[0])})
    else $error("software write did not set the flags");

  a_upper_zero: assert property (@(posedge clock) disable iff (rst)
    wb_ack_o && $past(rd_hit_flags) |-> wb_dat_o[31:2] == 30'h0000_0000)
    else $error("unimplemented bits read nonzero");

  a_flags_mapped: assert property (@(posedge clock) disable iff (rst)
    ack_d && rd_hit_flags && !brown_evt && !wr_now |=> wb_dat_o[1:0] == $past(flags_q))
    else $error("reset-cause register not at its index");

  a_other_keep: assert property (@(posedge clock) disable iff (rst)
    (watchdog_timer_reset || pin_bus.req_pulse) && !brown_evt && !wr_now |=> $stable(flags_q))
    else $error("pin or watchdog reset changed the flags");

  a_bod_disabled: assert property (@(posedge clock) disable iff (rst)
    !bod_en_s && !wr_now |=> $stable(flags_q[`RCF_BIT_BROWN]))
    else $error("brown-out flag moved with detection off");

  a_cause_sticky: assert property (@(posedge clock) disable iff (rst)
    watchdog_timer_reset |=> status_q[`RCF_BIT_DOG] ##1 (irq || !$past(mask_q[`RCF_BIT_DOG])))
    else $error("watchdog cause not recorded");

  a_ack_single: assert property (@(posedge clock) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  c_brown_seen: cover property (@(posedge clock) disable iff (rst)
    brown_evt ##1 !flags_q[`RCF_BIT_BROWN]);
  c_sw_restore: cover property (@(posedge clock) disable iff (rst)
    wr_now && hit(idx, `RCF_IDX_FLAGS) ##1 flags_q == 2'h3);
  c_pin_reset: cover property (@(posedge clock) disable iff (rst)
    $rose(external_reset_req));
  c_irq_fire: cover property (@(posedge clock) disable iff (rst)
    $rose(irq));
endmodule // rcf_top
`default_nettype wire

/* testbench/test_reset_cause_flags.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rcf_regs.svh"
module test_reset_cause_flags;
  import rcf_pkg::*;
  localparam logic [11:0] a_flags = {`RCF_IDX_FLAGS, 2'b00};
  localparam logic [11:0] a_status = {`RCF_IDX_STATUS, 2'b00};
  localparam logic [11:0] a_mask = {`RCF_IDX_MASK, 2'b00};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic pin_n = 1'b1;
  logic bo_ev = 1'b0;
  logic bo_en = 1'b1;
  logic dog_rst = 1'b0;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o;
  wire logic ext_req;
  wire logic por_f;
  wire logic brown_f;
  wire logic irq;
  int n_errors = 0;
  int checked = 0;
  // behavioural register model
  int flags_m;
  int status_m;
  int mask_m;
  int m;
  logic [31:0] q;

  rcf_top DUT (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .external_reset_pin_n(pin_n), .brownout_event(bo_ev), .brownout_detect_enable(bo_en),
    .watchdog_timer_reset(dog_rst), .external_reset_req(ext_req), .power_on_flag(por_f),
    .brownout_flag(brown_f), .irq(irq));

  // 40 mhz core clock
  always #12.5 clock = ~clock;

  task automatic complete_run();
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one classic wishbone cycle; waits on ack, only the hang guard ends a wait
  task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] d, input logic [3:0] sel,
                     output logic [31:0] rdata);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= d;
    // ack and data are read before this edge's updates land
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    rdata = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // random lanes above lane 0 must not matter
  task automatic wr(input logic [11:0] adr, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, adr, d, 4'($urandom) | 4'h1, r);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] adr, input int exp);
    logic [31:0] r;
    bus(1'b0, adr, 32'h0, 4'h1, r);
    chk(name, exp, r);
  endtask

  // flag copies lag the flags and irq lags status by a cycle
  task automatic outs();
    repeat (3) @(posedge clock);
    chk("power_on_flag", flags_m[1], por_f);
    chk("brownout_flag", flags_m[0], brown_f);
    chk("irq", (status_m & mask_m) != 0, irq);
  endtask

  // low pulse of n cycles on the pin; short ones must vanish in the filter
  task automatic pin(input int n, input logic exp);
    @(posedge clock);
    pin_n <= 1'b0;
    repeat (n) @(posedge clock);
    chk("external_reset_req", exp, ext_req);
    pin_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk("external_reset_req", 0, ext_req);
    if (exp) status_m |= 4;
  endtask

  // brown-out edge with detection on or off
  task automatic brown(input logic en);
    @(posedge clock);
    bo_en <= en;
    repeat (4) @(posedge clock);
    bo_ev <= 1'b1;
    repeat (6) @(posedge clock);
    bo_ev <= 1'b0;
    repeat (4) @(posedge clock);
    if (en) begin
      flags_m &= 2;
      status_m |= 1;
    end
  endtask

  task automatic power_on();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    flags_m = 0;
    status_m = 2;
    mask_m = 0;
    repeat (2) @(posedge clock);
    rd_chk("flags", a_flags, flags_m);
    rd_chk("status", a_status, status_m);
    rd_chk("mask", a_mask, mask_m);
    outs();
  endtask

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #(25 * 20000);
    n_errors++;
    complete_run();
  end

  // main sequence
  initial begin
    void'($urandom(60));
    power_on();
    for (int i = 0; i < 4; i++) begin
      wr(a_flags, ($urandom & 32'hfffffffc) | i);
      flags_m = i;
      rd_chk("flags", a_flags, flags_m);
      outs();
    end
    bus(1'b1, a_flags, 32'h0, 4'he, q);
    rd_chk("flags", a_flags, flags_m);
    wr(12'h100, $urandom);
    rd_chk("unmapped", 12'h100, 0);
    rd_chk("flags", a_flags, flags_m);
    @(posedge clock);
    dog_rst <= 1'b1;
    @(posedge clock);
    dog_rst <= 1'b0;
    status_m |= 8;
    rd_chk("status", a_status, status_m);
    rd_chk("flags", a_flags, flags_m);
    pin(40, 1'b0);
    pin(100, 1'b1);
    rd_chk("status", a_status, status_m);
    rd_chk("flags", a_flags, flags_m);
    brown(1'b0);
    rd_chk("flags", a_flags, flags_m);
    brown(1'b1);
    rd_chk("flags", a_flags, flags_m);
    rd_chk("status", a_status, status_m);
    outs();
    wr(a_flags, 32'h3);
    flags_m = 3;
    rd_chk("flags", a_flags, flags_m);
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 0 : ($urandom & 15);
      wr(a_mask, m);
      mask_m = m;
      rd_chk("mask", a_mask, mask_m);
      outs();
      m = $urandom & 15;
      wr(a_status, m);
      status_m &= ~m;
      rd_chk("status", a_status, status_m);
      outs();
    end
    power_on();
    complete_run();
  end
endmodule // test_reset_cause_flags
`default_nettype wire
